// ### core/p1gpio_port.sv
// Port 1 general I/O block: five pins with data, direction, pull-up and
// function select registers behind an AXI4-Lite slave.
// Assumes pin inputs are asynchronous and the shared peripherals run on
// ref_clk; edge sensing of the interrupt inputs lives in those units.
//
// Notes on behaviour
// RULE1: Pins 7..4 and 0 hold data bits; bits 3..1 read zero, ignore writes.
// RULE2: Output pins read back their stored data bit, not the pin.
// RULE3: Input pins read back the synchronised pin level.
// RULE4: Direction one drives the pin from its data bit; zero makes input.
// RULE5: Direction and data act only while the pin is general I/O.
// RULE6: Direction register is write-only and reads as all ones.
// RULE7: On an input pin, pull-up enable one turns the pull-up on.
// RULE8: Reset clears data, direction, pull-up; function select becomes 04.
// RULE9: Select bit 7 gives pin 7 to interrupt three and timer trigger.
// RULE10: Select bit 6 gives pin 6 to external interrupt two.
// RULE11: Select bit 5 gives pin 5 to external interrupt one.
// RULE12: Select bit 4 chooses general I/O or pulse-width output on pin 4.
// RULE13: Interrupt inputs are edge sensed by their units; pins pass level.
// RULE14: Select bit 4 one drives pulse-width output onto pin 4.
// RULE15: Select bit 0 one drives the timer clock output onto pin 0.
// RULE16: Select bit 2 reads one, bits 3 and 1 read zero; all ignore writes.
// RULE17: Pull-up stays off whenever the pin's direction bit is one.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module p1gpio_port
   import p1gpio_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // AXI4-Lite write address and data.
   input wire logic [17:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response.
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read.
   input wire logic [17:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pins.
   input wire logic [7:0] pinIn,
   output logic [7:0] pinOut,
   output logic [7:0] pinOe,
   output logic [7:0] pullUpOn,
   // Shared peripherals.
   input wire logic pulseWidthOut,
   input wire logic timerClockOut,
   output logic extIntThree,
   output logic extIntTwo,
   output logic extIntOne,
   output logic timer_trigger_input
);
   logic [7:0] port1_output_data;
   logic [7:0] port1_direction;
   logic [7:0] port1_pullup_enable;
   logic [7:0] port1_function_select;
   logic [7:0] pinMeta;
   logic [7:0] pinSync;
   logic [17:0] wAddr;
   logic wAddrHeld;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wDataHeld;
   logic [7:0] gpioMask;
   logic [7:0] readBack;
   logic [7:0] next_pinOut;
   logic [7:0] next_pinOe;
   logic next_wAddrHeld;
   logic next_wDataHeld;
   logic next_bvalid;
   logic next_rvalid;

   // Applies a byte write under strobe, keeping only the given bits.
   function automatic logic [7:0] wr_byte(input logic [7:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic [7:0] m);
      wr_byte = s[0] ? ((d[7:0] & m) | (old & ~m)) : old;
   endfunction

   // Two flip-flops before any logic looks at the pins.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= 8'h00;
         pinSync <= 8'h00;
      end else begin
         pinMeta <= pinIn;
         pinSync <= pinMeta;
      end
   end

   // Write channel capture; address and data may arrive in either order.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wAddrHeld <= 1'b0;
         wDataHeld <= 1'b0;
         wAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else if (wAddrHeld && wDataHeld) begin
         wAddrHeld <= 1'b0;
         wDataHeld <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            wAddrHeld <= 1'b1;
            wAddr <= awaddr;
         end
         if (wvalid && wready) begin
            wDataHeld <= 1'b1;
            wData <= wdata;
            wStrb <= wstrb;
         end
      end
   end

   // Next handshake state, mirrored from the channel logic, so ready flops.
   always_comb begin
      next_wAddrHeld = !(wAddrHeld && wDataHeld) &&
         (wAddrHeld || (awvalid && awready));
      next_wDataHeld = !(wAddrHeld && wDataHeld) &&
         (wDataHeld || (wvalid && wready));
      next_bvalid = (wAddrHeld && wDataHeld) || (bvalid && !bready);
      next_rvalid = (arvalid && arready) || (rvalid && !rready);
   end

   // Registered ready tracks the held flags and bvalid exactly, so it costs no cycle.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
      end else begin
         awready <= !next_wAddrHeld && !next_bvalid;
         wready <= !next_wDataHeld && !next_bvalid;
         arready <= !next_rvalid;
      end
   end

   // Register writes; reserved bits are masked so they never change.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // RULE8 reset values
         port1_output_data <= RST_OUTPUT_DATA;
         port1_direction <= RST_DIRECTION;
         port1_pullup_enable <= RST_PULLUP_ENABLE;
         port1_function_select <= RST_FUNCTION_SELECT;
      end else if (wAddrHeld && wDataHeld) begin
         // RULE1 reserved data bits
         if (wAddr == ADDR_OUTPUT_DATA) begin
            port1_output_data <= wr_byte(port1_output_data, wData, wStrb,
               PIN_MASK);
         end else if (wAddr == ADDR_DIRECTION) begin
            port1_direction <= wr_byte(port1_direction, wData, wStrb,
               PIN_MASK);
         end else if (wAddr == ADDR_PULLUP_ENABLE) begin
            port1_pullup_enable <= wr_byte(port1_pullup_enable, wData,
               wStrb, PIN_MASK);
         end else if (wAddr == ADDR_FUNCTION_SELECT) begin
            // RULE16 fixed reserved bits
            port1_function_select <= wr_byte(port1_function_select, wData,
               wStrb, PIN_MASK) | SEL_FIXED_ONES;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wAddrHeld && wDataHeld) begin
         bvalid <= 1'b1;
         if (wAddr == ADDR_OUTPUT_DATA || wAddr == ADDR_DIRECTION ||
            wAddr == ADDR_PULLUP_ENABLE || wAddr == ADDR_FUNCTION_SELECT) begin
            bresp <= RESP_OKAY;
         end else begin
            bresp <= RESP_SLVERR;
         end
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Port read value: stored data on outputs, pin level on inputs.
   always_comb begin
      // RULE2 output pins
      // RULE3 input pins
      readBack = ((port1_direction & port1_output_data) |
         (~port1_direction & pinSync)) & PIN_MASK;
   end

   // Read channel; one read at a time, answered one cycle after address.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         if (araddr == ADDR_OUTPUT_DATA) begin
            rdata <= {24'h000000, readBack};
         end else if (araddr == ADDR_DIRECTION) begin
            // RULE6 write-only reads ones
            rdata <= {24'h000000, DIR_READ_VALUE};
         end else if (araddr == ADDR_PULLUP_ENABLE) begin
            rdata <= {24'h000000, port1_pullup_enable};
         end else if (araddr == ADDR_FUNCTION_SELECT) begin
            rdata <= {24'h000000, port1_function_select};
         end else begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // Pin ownership: general I/O unless the select bit hands it over.
   always_comb begin
      gpioMask = PIN_MASK & ~port1_function_select;
      // RULE4 direction drives pin
      // RULE5 only in general I/O
      next_pinOut = port1_output_data & gpioMask;
      next_pinOe = port1_direction & gpioMask;
      // RULE12 pin 4 selection
      // RULE14 pulse-width output
      if (port1_function_select[SEL_PULSE_WIDTH]) begin
         next_pinOut[SEL_PULSE_WIDTH] = pulseWidthOut;
         next_pinOe[SEL_PULSE_WIDTH] = 1'b1;
      end
      // RULE15 timer clock output
      if (port1_function_select[SEL_TIMER_CLOCK]) begin
         next_pinOut[SEL_TIMER_CLOCK] = timerClockOut;
         next_pinOe[SEL_TIMER_CLOCK] = 1'b1;
      end
   end

   // Pin and peripheral outputs are registered, adding one cycle of delay.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinOut <= 8'h00;
         pinOe <= 8'h00;
         pullUpOn <= 8'h00;
         extIntThree <= 1'b1;
         extIntTwo <= 1'b1;
         extIntOne <= 1'b1;
         timer_trigger_input <= 1'b1;
      end else begin
         pinOut <= next_pinOut;
         pinOe <= next_pinOe;
         // RULE7 pull-up on inputs
         // RULE17 off for outputs
         pullUpOn <= port1_pullup_enable & ~port1_direction & PIN_MASK;
         // RULE9 interrupt three and trigger
         // RULE13 level passed for sensing
         extIntThree <= port1_function_select[SEL_EXT_INT_THREE] ?
            pinSync[SEL_EXT_INT_THREE] : 1'b1;
         timer_trigger_input <= port1_function_select[SEL_EXT_INT_THREE] ?
            pinSync[SEL_EXT_INT_THREE] : 1'b1;
         // RULE10 interrupt two
         extIntTwo <= port1_function_select[SEL_EXT_INT_TWO] ?
            pinSync[SEL_EXT_INT_TWO] : 1'b1;
         // RULE11 interrupt one
         extIntOne <= port1_function_select[SEL_EXT_INT_ONE] ?
            pinSync[SEL_EXT_INT_ONE] : 1'b1;
      end
   end

   // Checks on the pin side and register map.
   property p_resv_data;
      @(posedge ref_clk) disable iff (!rst_n)
      (port1_output_data[3:1] == 3'b000) &&
      (port1_function_select[3:1] == 3'b010);
   endproperty
   a_resv_data: assert property (p_resv_data) // RULE1
      else $error("Reserved register bits changed.");

   property p_out_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (arvalid && arready && araddr == ADDR_OUTPUT_DATA &&
       port1_direction[7]) |=> (rdata[7] == $past(port1_output_data[7]));
   endproperty
   a_out_read: assert property (p_out_read) // RULE2
      else $error("Output pin read did not return stored data.");

   property p_in_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (arvalid && arready && araddr == ADDR_OUTPUT_DATA &&
       !port1_direction[5]) |=> (rdata[5] == $past(pinSync[5]));
   endproperty
   a_in_read: assert property (p_in_read) // RULE3
      else $error("Input pin read did not return pin level.");

   property p_drive;
      @(posedge ref_clk) disable iff (!rst_n)
      (port1_direction[6] && !port1_function_select[6]) |=>
      (pinOe[6] && pinOut[6] == $past(port1_output_data[6]));
   endproperty
   a_drive: assert property (p_drive) // RULE4
      else $error("Output pin not driven from its data bit.");

   property p_alt_only;
      @(posedge ref_clk) disable iff (!rst_n)
      port1_function_select[5] |=> !pinOe[5];
   endproperty
   a_alt_only: assert property (p_alt_only) // RULE5
      else $error("Pin driven while given to interrupt input.");

   property p_dir_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (arvalid && arready && araddr == ADDR_DIRECTION) |=>
      (rvalid && rdata[7:0] == 8'hff);
   endproperty
   a_dir_read: assert property (p_dir_read) // RULE6
      else $error("Direction register did not read as ones.");

   property p_pull;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (pullUpOn == ($past(port1_pullup_enable) &
         ~$past(port1_direction) & PIN_MASK));
   endproperty
   a_pull: assert property (p_pull) // RULE17
      else $error("Pull-up state wrong for pin direction.");

   property p_pwm;
      @(posedge ref_clk) disable iff (!rst_n)
      port1_function_select[4] |=>
      (pinOe[4] && pinOut[4] == $past(pulseWidthOut));
   endproperty
   a_pwm: assert property (p_pwm) // RULE14
      else $error("Pulse-width output not on pin 4.");

   property p_tclk;
      @(posedge ref_clk) disable iff (!rst_n)
      port1_function_select[0] |=>
      (pinOe[0] && pinOut[0] == $past(timerClockOut));
   endproperty
   a_tclk: assert property (p_tclk) // RULE15
      else $error("Timer clock output not on pin 0.");

   property p_ext_interrupt_three_select;
      @(posedge ref_clk) disable iff (!rst_n)
      port1_function_select[7] |=> (extIntThree == $past(pinSync[7]));
   endproperty
   a_ext_interrupt_three_select: assert property (p_ext_interrupt_three_select) // RULE9
      else $error("Interrupt three input not following pin 7.");

   c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
      bvalid && bready && bresp == RESP_OKAY);
   c_read: cover property (@(posedge ref_clk) disable iff (!rst_n)
      rvalid && rready);
   c_pwm: cover property (@(posedge ref_clk) disable iff (!rst_n)
      pinOe[4] && port1_function_select[4]);
endmodule
`default_nettype wire

// ### core/p1gpio_pkg.sv
// Package for the port 1 general I/O block: register map, reset values,
// field positions and bus answer codes.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package p1gpio_pkg;
   // Printed offsets are not all multiples of four, so they are indices.
   localparam logic [15:0] IDX_OUTPUT_DATA = 16'hffd4;
   localparam logic [15:0] IDX_DIRECTION = 16'hffe4;
   localparam logic [15:0] IDX_PULLUP_ENABLE = 16'hffed;
   localparam logic [15:0] IDX_FUNCTION_SELECT = 16'hfffc;
   localparam int ADDR_W = 18;
   // Byte address is four times the index.
   localparam logic [17:0] ADDR_OUTPUT_DATA = {IDX_OUTPUT_DATA, 2'b00};
   localparam logic [17:0] ADDR_DIRECTION = {IDX_DIRECTION, 2'b00};
   localparam logic [17:0] ADDR_PULLUP_ENABLE = {IDX_PULLUP_ENABLE, 2'b00};
   localparam logic [17:0] ADDR_FUNCTION_SELECT =
      {IDX_FUNCTION_SELECT, 2'b00};
   // Reset values.
   localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_PULLUP_ENABLE = 8'h00;
   localparam logic [7:0] RST_FUNCTION_SELECT = 8'h04;
   // Implemented pin bits 7..4 and 0; bit 2 of select reads as one.
   localparam logic [7:0] PIN_MASK = 8'hf1;
   localparam logic [7:0] SEL_FIXED_ONES = 8'h04;
   localparam logic [7:0] DIR_READ_VALUE = 8'hff;
   // Function select field positions.
   localparam int SEL_EXT_INT_THREE = 7;
   localparam int SEL_EXT_INT_TWO = 6;
   localparam int SEL_EXT_INT_ONE = 5;
   localparam int SEL_PULSE_WIDTH = 4;
   localparam int SEL_TIMER_CLOCK = 0;
   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### testbench/p1gpio_pin_model.sv
// Pin and shared peripheral model for the port 1 block.
// Assumes the bench sets outside drivers and peripheral output levels.
`timescale 1ns/100ps
`default_nettype none
module p1gpio_pin_model (
   // Design pin side.
   input wire logic ref_clk,
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic [7:0] pullUpOn,
   output logic [7:0] pinIn,
   // Bench controls.
   input wire logic [7:0] extDrive,
   input wire logic [7:0] extEn,
   input wire logic [1:0] perLevel,
   // Peripheral outputs.
   output logic pulseWidthOut,
   output logic timerClockOut
);
   logic [7:0] floatPat = 8'h55;
   // A floating pin flips every cycle, so no stale level can pass.
   always @(posedge ref_clk) floatPat <= ~floatPat;
   // An outside driver beats the port, which shows reads ignore the pin.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (extEn[i]) pinIn[i] = extDrive[i];
         else if (pinOe[i]) pinIn[i] = pinOut[i];
         else if (pullUpOn[i]) pinIn[i] = 1'b1;
         else pinIn[i] = floatPat[i];
      end
   end
   // Peripheral sources are held steady by the bench.
   assign pulseWidthOut = perLevel[0];
   assign timerClockOut = perLevel[1];
endmodule
`default_nettype wire

// ### testbench/p1gpio_port_tb.sv
// Self-checking bench for the port 1 block over AXI4-Lite.
// Assumes the pin model stands on the far side of the pins.
`timescale 1ns/100ps
`default_nettype none
module p1gpio_port_tb
   import p1gpio_pkg::*;
   ;
   logic ref_clk = 1'b0, rst_n = 1'b0;
   logic [17:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, perLevel = 2'b00;
   logic [7:0] pinIn, pinOut, pinOe, pullUpOn;
   logic [7:0] extDrive = 8'h00, extEn = 8'hff;
   logic pwmOut, tmrOut, extIntThree, extIntTwo, extIntOne, trig;
   logic [15:0] lfsr = 16'hb438;
   logic [33:0] rdQ[$], rdExp;
   logic [1:0] bQ[$];
   int miscompares = 0, n_checks = 0, cycles = 0;

   p1gpio_port DUT (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .pullUpOn(pullUpOn), .pulseWidthOut(pwmOut),
      .timerClockOut(tmrOut), .extIntThree(extIntThree),
      .extIntTwo(extIntTwo), .extIntOne(extIntOne),
      .timer_trigger_input(trig));
   p1gpio_pin_model pins (.ref_clk(ref_clk), .pinOut(pinOut),
      .pinOe(pinOe), .pullUpOn(pullUpOn), .pinIn(pinIn),
      .extDrive(extDrive), .extEn(extEn), .perLevel(perLevel),
      .pulseWidthOut(pwmOut), .timerClockOut(tmrOut));

   // Clock at 10 MHz.
   always #50 ref_clk = ~ref_clk;

   function automatic logic [15:0] nextRnd(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (miscompares == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Write one byte; both halves offered together, each released when taken.
   task automatic wr(logic [17:0] a, logic [7:0] d, logic [1:0] er);
      bQ.push_back(er);
      awaddr <= a;
      wdata <= {lfsr, 8'h00, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      do @(posedge ref_clk); while (!bvalid);
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Read and note the expected byte and answer code for the watcher.
   task automatic rd(logic [17:0] a, logic [7:0] d, logic [1:0] er);
      rdQ.push_back({er, 24'h0, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (!(arvalid && arready));
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (!rvalid);
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Compare each answer with the oldest note as it is handed over.
   always @(posedge ref_clk) begin
      if (bvalid && bready) check("bresp", bresp, bQ.pop_front());
      if (rvalid && rready) begin
         rdExp = rdQ.pop_front();
         check("rdata", rdata, rdExp[31:0]);
         check("rresp", rresp, rdExp[33:32]);
      end
   end

   // A hang ends the run as a failure.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      logic [7:0] d, r, p, e, x, lv;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // Reset state, seen at the pins and through the bus.
      check("pinOe", pinOe, 8'h00);
      check("extInts", {extIntThree, extIntTwo, extIntOne, trig}, 4'hf);
      rd(ADDR_OUTPUT_DATA, 8'h00, RESP_OKAY);
      rd(ADDR_DIRECTION, 8'hff, RESP_OKAY);
      rd(ADDR_PULLUP_ENABLE, 8'h00, RESP_OKAY);
      rd(ADDR_FUNCTION_SELECT, 8'h04, RESP_OKAY);
      rd(18'h00010, 8'h00, RESP_SLVERR);
      wr(18'h00010, 8'hff, RESP_SLVERR);
      // Random data, direction and pull-up with outside drivers fighting.
      for (int k = 0; k < 8; k++) begin
         lfsr = nextRnd(lfsr);
         d = lfsr[7:0];
         r = lfsr[15:8];
         lfsr = nextRnd(lfsr);
         p = lfsr[7:0];
         x = lfsr[15:8];
         lfsr = nextRnd(lfsr);
         e = lfsr[7:0] | ~(r | p);
         extDrive <= x;
         extEn <= e;
         wr(ADDR_OUTPUT_DATA, d, RESP_OKAY);
         wr(ADDR_DIRECTION, r, RESP_OKAY);
         wr(ADDR_PULLUP_ENABLE, p, RESP_OKAY);
         repeat (5) @(posedge ref_clk);
         lv = (e & x) | ~e;
         check("pinOe", pinOe, r & PIN_MASK);
         check("pinOut", pinOut & pinOe, d & r & PIN_MASK);
         check("pullUpOn", pullUpOn, p & ~r & PIN_MASK);
         rd(ADDR_OUTPUT_DATA, ((d & r) | (lv & ~r)) & PIN_MASK, RESP_OKAY);
         rd(ADDR_PULLUP_ENABLE, p & PIN_MASK, RESP_OKAY);
         rd(ADDR_DIRECTION, DIR_READ_VALUE, RESP_OKAY);
      end
      // Hand every pin to its alternate function and swing the sources.
      wr(ADDR_FUNCTION_SELECT, 8'hff, RESP_OKAY);
      wr(ADDR_DIRECTION, 8'hff, RESP_OKAY);
      rd(ADDR_FUNCTION_SELECT, 8'hf5, RESP_OKAY);
      for (int j = 0; j < 2; j++) begin
         x = j ? 8'h5f : 8'ha0;
         extDrive <= x;
         extEn <= 8'he0;
         perLevel <= j ? 2'b10 : 2'b01;
         repeat (5) @(posedge ref_clk);
         check("pinOe", pinOe, 8'h11);
         check("pwmPin", pinOut[4], perLevel[0]);
         check("tmrPin", pinOut[0], perLevel[1]);
         check("extThree", {extIntThree, trig}, {2{x[7]}});
         check("extTwo", extIntTwo, x[6]);
         check("extOne", extIntOne, x[5]);
      end
      // Reserved select bits keep their fixed values on write.
      wr(ADDR_FUNCTION_SELECT, 8'h0a, RESP_OKAY);
      rd(ADDR_FUNCTION_SELECT, 8'h04, RESP_OKAY);
      check("pinOe", pinOe, 8'hf1);
      // A write without byte 0 enabled must leave the pull-ups alone.
      wstrb <= 4'he;
      wr(ADDR_PULLUP_ENABLE, 8'hff, RESP_OKAY);
      wstrb <= 4'hf;
      rd(ADDR_PULLUP_ENABLE, p & PIN_MASK, RESP_OKAY);
      stop_test();
   end
endmodule
`default_nettype wire
